// ==== logic/mcu_reset_sequencer_pkg.sv ====
// constants and types shared by the reset sequencer
package mcu_reset_sequencer_pkg;
   localparam int CLK_HZ = 50000000;
   localparam int GUARD_QUAL_MS = 1;
   localparam int GUARD_QUAL_CYC = (CLK_HZ / 1000) * GUARD_QUAL_MS;
   localparam int STARTUP_CYC = 1024;
   localparam int TIMER_W = 16;
   localparam int PC_W = 14;
   localparam int SP_W = 4;
   localparam int PORT_W = 8;
   localparam int NUM_PORTS = 4;
   localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
   localparam logic [SP_W-1:0] SP_ZERO = 4'h0;
   localparam logic [SP_W-1:0] SP_TOP = 4'hB;
   localparam logic [PORT_W-1:0] PORT_ALL_ONES = 8'hFF;
   localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
   localparam logic [TIMER_W-1:0] TIMER_ONE = 16'h0001;

   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_STARTUP = 3'b010,
      ST_RUN = 3'b100
   } seq_state_t;
endpackage

// ==== logic/qual_counter.sv ====
// saturating qualification counter: flags when a level has held for more than LIMIT cycles
`timescale 1ns/1ps
module qual_counter #(
   parameter int LIMIT = 50000,
   parameter int W = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // level being qualified
   input wire logic level,
   // high once level has lasted beyond LIMIT cycles
   output logic expired
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic expired;
   } qual_state_t;
   localparam logic [W-1:0] LIMIT_W = W'(LIMIT);
   localparam logic [W-1:0] ONE_W = W'(1);
   qual_state_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      if (!level) begin
         s_d.cnt = '0;
         s_d.expired = 1'b0;
      end else if (s_q.cnt < LIMIT_W) begin
         s_d.cnt = s_q.cnt + ONE_W;
      end else begin
         s_d.expired = 1'b1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign expired = s_q.expired;
endmodule

// ==== logic/mcu_reset_sequencer.sv ====
// chip reset sequencer: combines reset sources, start-up delay, flags and init values
// Function
// RL1 - power-on reset clears program counter to zero
// RL2 - power-on loads all port data and direction registers with ones
// RL3 - after pin release, wait start-up delay before normal operation
// RL4 - pin pulled low while running does normal reset, resumes when high
// RL5 - supply-drop reset only after low lasts beyond 1ms qualification
// RL6 - supply-drop guard enabled by option, threshold paired with warning level
// RL7 - watchdog expiry when running resets like pin, sets expiry flag
// RL8 - watchdog expiry in power-down clears only PC and SP, sets flag
// RL9 - flags: power-on clears both, pin/drop keep, watchdog sets accordingly
// RL10 - power-on disables interrupts, stops timers, clears prescaler, SP to top
// RL11 - all sources merged into one reset released synchronously after start-up
`timescale 1ns/1ps
module mcu_reset_sequencer #(
   parameter int STARTUP_CYCLES = mcu_reset_sequencer_pkg::STARTUP_CYC,
   parameter int GUARD_QUAL_CYCLES = mcu_reset_sequencer_pkg::GUARD_QUAL_CYC
) (
   // clock and power-on reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // asynchronous sources
   input wire logic externalInitPin_b,
   input wire logic supplyLow,
   input wire logic watchdogTimeout,
   input wire logic cpuPoweredDown,
   // configuration options
   input wire logic supplyDropGuardEn,
   input wire logic [1:0] thresholdPairSel,
   // chip reset and per-block init controls
   output logic chipReset,
   output logic pcClear,
   output logic spClear,
   output logic [mcu_reset_sequencer_pkg::SP_W-1:0] spValue,
   output logic portInit,
   output logic [mcu_reset_sequencer_pkg::PORT_W*mcu_reset_sequencer_pkg::NUM_PORTS-1:0]
      portInitValue,
   output logic peripheralInit,
   // flags and thresholds
   output logic watchdogExpiryFlag,
   output logic powerdownFlag,
   output logic [1:0] guardThresholdSel,
   output logic [1:0] warnThresholdSel
);
   localparam int TW = mcu_reset_sequencer_pkg::TIMER_W;
   localparam logic [TW-1:0] START_LIMIT = TW'(STARTUP_CYCLES);

   typedef struct packed {
      logic [1:0] pinSync;
      logic [1:0] lowSync;
      logic [1:0] wdSync;
      logic [1:0] pdSync;
      logic wdPrev;
      mcu_reset_sequencer_pkg::seq_state_t st;
      logic [TW-1:0] timer;
      logic chipReset;
      logic pcClear;
      logic spClear;
      logic [mcu_reset_sequencer_pkg::SP_W-1:0] spValue;
      logic portInit;
      logic peripheralInit;
      logic wdFlag;
      logic pdFlag;
      logic [1:0] guardSel;
      logic [1:0] warnSel;
   } seq_reg_t;

   seq_reg_t s_q, s_d;
   logic guardTrip;
   logic pinLow;
   logic wdEvent;

   // supply-drop qualification; short dips never reach LIMIT
   qual_counter #(.LIMIT(GUARD_QUAL_CYCLES), .W(TW)) u_guard (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .level(s_q.lowSync[1] & supplyDropGuardEn), // see RL5 see RL6
      .expired(guardTrip)
   );

   always_comb begin
      s_d = s_q;
      // two-stage synchronisers; bit 0 feeds only bit 1
      s_d.pinSync = {s_q.pinSync[0], externalInitPin_b};
      s_d.lowSync = {s_q.lowSync[0], supplyLow};
      s_d.wdSync = {s_q.wdSync[0], watchdogTimeout};
      s_d.pdSync = {s_q.pdSync[0], cpuPoweredDown};
      s_d.wdPrev = s_q.wdSync[1];
      pinLow = ~s_q.pinSync[1];
      wdEvent = s_q.wdSync[1] & ~s_q.wdPrev;
      // one-shot controls, default off
      s_d.pcClear = 1'b0;
      s_d.spClear = 1'b0;
      s_d.portInit = 1'b0;
      s_d.peripheralInit = 1'b0;
      s_d.guardSel = thresholdPairSel; // see RL6
      s_d.warnSel = thresholdPairSel; // see RL6
      unique case (s_q.st)
         mcu_reset_sequencer_pkg::ST_HOLD: begin
            s_d.chipReset = 1'b1;
            s_d.timer = mcu_reset_sequencer_pkg::TIMER_ZERO;
            if (!pinLow && !guardTrip) begin
               s_d.st = mcu_reset_sequencer_pkg::ST_STARTUP; // see RL3
            end
         end
         mcu_reset_sequencer_pkg::ST_STARTUP: begin
            s_d.chipReset = 1'b1;
            if (pinLow || guardTrip) begin
               s_d.st = mcu_reset_sequencer_pkg::ST_HOLD;
            end else if (s_q.timer >= START_LIMIT - mcu_reset_sequencer_pkg::TIMER_ONE) begin
               s_d.st = mcu_reset_sequencer_pkg::ST_RUN; // see RL11
               s_d.chipReset = 1'b0; // see RL11
            end else begin
               s_d.timer = s_q.timer + mcu_reset_sequencer_pkg::TIMER_ONE; // see RL3
            end
         end
         mcu_reset_sequencer_pkg::ST_RUN: begin
            if (pinLow || guardTrip) begin
               // normal-operation reset, flags untouched
               s_d.st = mcu_reset_sequencer_pkg::ST_HOLD; // see RL4 see RL5 see RL9
               s_d.chipReset = 1'b1;
               s_d.pcClear = 1'b1; // see RL4
               s_d.spClear = 1'b1;
               s_d.spValue = mcu_reset_sequencer_pkg::SP_TOP;
               s_d.portInit = 1'b1;
               s_d.peripheralInit = 1'b1;
            end else if (wdEvent && s_q.pdSync[1]) begin
               // wake from power-down: most state kept
               s_d.pcClear = 1'b1; // see RL8
               s_d.spClear = 1'b1; // see RL8
               s_d.spValue = mcu_reset_sequencer_pkg::SP_ZERO; // see RL8
               s_d.wdFlag = 1'b1; // see RL8 see RL9
               s_d.pdFlag = 1'b1; // see RL9
            end else if (wdEvent) begin
               s_d.st = mcu_reset_sequencer_pkg::ST_STARTUP; // see RL7
               s_d.timer = mcu_reset_sequencer_pkg::TIMER_ZERO;
               s_d.chipReset = 1'b1;
               s_d.pcClear = 1'b1;
               s_d.spClear = 1'b1;
               s_d.spValue = mcu_reset_sequencer_pkg::SP_TOP;
               s_d.portInit = 1'b1;
               s_d.peripheralInit = 1'b1;
               s_d.wdFlag = 1'b1; // see RL7 see RL9
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         // power-on: everything to its defined start state
         s_q <= '0;
         // pin reads low until synchronised, so start-up never begins on a stale level
         s_q.pinSync <= 2'b00;
         s_q.st <= mcu_reset_sequencer_pkg::ST_HOLD;
         s_q.chipReset <= 1'b1; // see RL11
         s_q.pcClear <= 1'b1; // see RL1
         s_q.spClear <= 1'b1; // see RL10
         s_q.spValue <= mcu_reset_sequencer_pkg::SP_TOP; // see RL10
         s_q.portInit <= 1'b1; // see RL2
         s_q.peripheralInit <= 1'b1; // see RL10
         s_q.wdFlag <= 1'b0; // see RL9
         s_q.pdFlag <= 1'b0; // see RL9
      end else begin
         s_q <= s_d;
      end
   end

   // per-block pulses are held through power-on so blocks see them while reset stands
   assign chipReset = s_q.chipReset;
   assign pcClear = s_q.pcClear;
   assign spClear = s_q.spClear;
   assign spValue = s_q.spValue;
   assign portInit = s_q.portInit;
   assign portInitValue =
      {mcu_reset_sequencer_pkg::NUM_PORTS{mcu_reset_sequencer_pkg::PORT_ALL_ONES}}; // see RL2
   assign peripheralInit = s_q.peripheralInit;
   assign watchdogExpiryFlag = s_q.wdFlag;
   assign powerdownFlag = s_q.pdFlag;
   assign guardThresholdSel = s_q.guardSel;
   assign warnThresholdSel = s_q.warnSel;
endmodule

// ==== tb/mcu_reset_sequencer_assertions.sv ====
// concurrent checks on the reset sequencer ports
`timescale 1ns/1ps
module mcu_reset_sequencer_assertions (
   // clock, reset and sources
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic externalInitPin_b,
   input wire logic supplyLow,
   input wire logic watchdogTimeout,
   input wire logic cpuPoweredDown,
   input wire logic supplyDropGuardEn,
   input wire logic [1:0] thresholdPairSel,
   // outputs
   input wire logic chipReset,
   input wire logic pcClear,
   input wire logic spClear,
   input wire logic [3:0] spValue,
   input wire logic portInit,
   input wire logic [31:0] portInitValue,
   input wire logic peripheralInit,
   input wire logic watchdogExpiryFlag,
   input wire logic powerdownFlag,
   input wire logic [1:0] guardThresholdSel,
   input wire logic [1:0] warnThresholdSel
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence wdRise;
      $rose(watchdogTimeout) && !chipReset;
   endsequence
   por_init_a: assert property ($rose(rst_b) |-> chipReset && pcClear
      && portInit && peripheralInit && spValue == 4'hB && portInitValue == 32'hFFFFFFFF
      && !watchdogExpiryFlag && !powerdownFlag) else $error("power-on init wrong");
   pin_hold_a: assert property ((!externalInitPin_b)[*4] |-> chipReset)
      else $error("pin low without chip reset");
   startup_delay_a: assert property ($fell(chipReset) |-> $past(chipReset, 8)
      && $past(externalInitPin_b, 8)) else $error("release before start-up delay");
   full_init_a: assert property ($rose(chipReset) |-> pcClear && portInit
      && peripheralInit && spValue == 4'hB) else $error("full reset init missing");
   // a trip must trace to the pin, the watchdog or a qualified supply drop
   guard_qual_a: assert property ($rose(chipReset) |->
      !$past(externalInitPin_b, 3) || $past(watchdogTimeout, 3)
      || ($past(supplyLow, 21) && supplyDropGuardEn))
      else $error("unqualified chip reset");
   wd_run_a: assert property (wdRise and !cpuPoweredDown |-> ##[2:4]
      (chipReset && watchdogExpiryFlag)) else $error("watchdog run reset wrong");
   wd_down_a: assert property (wdRise and cpuPoweredDown |-> ##[2:4] (pcClear
      && spClear && spValue == 4'h0 && watchdogExpiryFlag && powerdownFlag && !chipReset))
      else $error("watchdog power-down reset wrong");
   sel_pair_a: assert property ($changed(thresholdPairSel) |-> ##[1:3]
      (guardThresholdSel == thresholdPairSel && warnThresholdSel == thresholdPairSel))
      else $error("threshold pair not copied");
endmodule
bind mcu_reset_sequencer mcu_reset_sequencer_assertions u_mcu_reset_sequencer_assertions (.*);

// ==== tb/reset_switch.sv ====
// external reset switch with pull-up on the init pin
`timescale 1ns/1ps
module reset_switch (
   // clock and contact, closed while high
   input wire logic sys_clk,
   input wire logic press,
   // init pin, active low
   output logic externalInitPin_b
);
   // contact settles one edge after the press, pull-up wins when open
   always @(posedge sys_clk) externalInitPin_b <= !press;
endmodule

// ==== tb/tb_mcu_reset_sequencer.sv ====
// testbench for the reset sequencer
`timescale 1ns/1ps
module tb_mcu_reset_sequencer;
   logic sys_clk = 1'b0, rst_b = 1'b0, press = 1'b0, supplyLow = 1'b0;
   logic watchdogTimeout = 1'b0, cpuPoweredDown = 1'b0, supplyDropGuardEn = 1'b1;
   logic [1:0] thresholdPairSel = 2'h0, guardThresholdSel, warnThresholdSel;
   logic externalInitPin_b, chipReset, pcClear, spClear, portInit, peripheralInit;
   logic watchdogExpiryFlag, powerdownFlag;
   logic [3:0] spValue;
   logic [31:0] portInitValue;
   int errors = 0, nTests = 0, cnt;
   reset_switch u_reset_switch (.sys_clk(sys_clk), .press(press),
      .externalInitPin_b(externalInitPin_b));
   // short counts keep the run brief
   mcu_reset_sequencer #(.STARTUP_CYCLES(8), .GUARD_QUAL_CYCLES(20)) u_mcu_reset_sequencer (.*);
   initial forever #10 sys_clk = ~sys_clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("errors=%0d checks=%0d", errors, nTests);
      if (errors == 0 && nTests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic runWait;
      cnt = 0;
      while (chipReset !== 1'b0 && cnt < 200) begin
         @(negedge sys_clk);
         cnt++;
      end
   endtask
   // 0 pin, 1 supply low, 2 watchdog held n cycles
   task automatic hit(input int which, input int n, input logic exp);
      @(posedge sys_clk);
      press <= (which == 0);
      supplyLow <= (which == 1);
      watchdogTimeout <= (which == 2);
      repeat (n) @(posedge sys_clk);
      {press, supplyLow, watchdogTimeout} <= 3'h0;
      repeat (4) @(negedge sys_clk);
      chk(chipReset, exp);
      runWait();
      chk(chipReset, 1'b0);
      $display("test source %0d done", which);
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({chipReset, pcClear, spClear, portInit, peripheralInit}, 5'h1F);
      chk(spValue, 4'hB);
      chk({watchdogExpiryFlag, powerdownFlag}, 2'h0);
      chk(portInitValue, 32'hFFFFFFFF);
      @(posedge sys_clk);
      rst_b <= 1'b1;
      runWait();
      chk(cnt >= 8 && cnt <= 12, 1'b1);
      $display("test power-on done");
      hit(0, 6, 1'b1);
      hit(1, 18, 1'b0);
      hit(1, 40, 1'b1);
      @(posedge sys_clk);
      supplyDropGuardEn <= 1'b0;
      hit(1, 40, 1'b0);
      chk({watchdogExpiryFlag, powerdownFlag}, 2'h0);
      hit(2, 5, 1'b1);
      chk({watchdogExpiryFlag, powerdownFlag}, 2'h2);
      @(posedge sys_clk);
      cpuPoweredDown <= 1'b1;
      hit(2, 5, 1'b0);
      chk({watchdogExpiryFlag, powerdownFlag}, 2'h3);
      @(posedge sys_clk);
      cpuPoweredDown <= 1'b0;
      hit(0, 6, 1'b1);
      chk({watchdogExpiryFlag, powerdownFlag}, 2'h3);
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         thresholdPairSel <= 2'(i);
         repeat (3) @(negedge sys_clk);
         chk({guardThresholdSel, warnThresholdSel}, {2'(i), 2'(i)});
      end
      $display("test threshold done");
      // a second power-on must clear both flags again
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      chk({chipReset, watchdogExpiryFlag, powerdownFlag}, 3'h4);
      runWait();
      chk(cnt >= 8 && cnt <= 12, 1'b1);
      $display("test second reset done");
      results();
   end
   // whole sequence needs well under a thousand cycles
   initial begin
      #100us;
      errors++;
      results();
   end
endmodule
